// ==== inc/dsw_cfg.svh ====
// constants for the dual switch mode and channel control block
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH
`define DSW_CLK_MHZ 100
`define DSW_CYC_PER_MS (`DSW_CLK_MHZ * 1000)
`define DSW_T_IN_MS 250
`define DSW_T_WDTO_MS 310
`define DSW_T_AVAIL_US 50
`define DSW_INT_DIV 390
`define DSW_A_GCR 8'h00
`define DSW_A_PWMR0 8'h04
`define DSW_A_CONFR0 8'h0C
`define DSW_A_OCR0 8'h14
`define DSW_A_GLOBAL_STATUS_REGISTER 8'h1C
`define DSW_A_FLTR0 8'h20
`define DSW_A_CH_STEP 8'h04
`define DSW_WD_BIT 15
`define DSW_GCR_PAR 0
`define DSW_GCR_WDDIS 4
`define DSW_PW_DUTY_LO 0
`define DSW_PW_ON 8
`define DSW_CF_PWMEN 0
`define DSW_CF_CLKINT 1
`define DSW_CF_DIREN 2
`define DSW_CF_DLY_LO 8
`define DSW_OC_PR_LO 0
`define DSW_RST_GCR 16'h0000
`define DSW_RST_PWMR 16'h0000
`define DSW_RST_CONFR 16'h0004
`define DSW_RST_OCR 16'h0000
`endif

// ==== inc/dsw_pkg.sv ====
// types for the dual switch mode and channel control block
package dsw_pkg;
   typedef enum logic [3:0] {
      DSW_SLEEP = 4'h1,
      DSW_NORMAL = 4'h2,
      DSW_FAILSAFE = 4'h4,
      DSW_FAULT = 4'h8
   } dsw_mode_t;
endpackage : dsw_pkg

// ==== verilog/dsw_act.sv ====
// pin synchroniser with edge detect and inactivity timeout
`timescale 1ns/1ps
`include "dsw_cfg.svh"
module dsw_act import dsw_pkg::*; #(
   parameter int unsigned TMO = `DSW_T_IN_MS * `DSW_CYC_PER_MS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   output logic o_lvl,
   output logic o_rise,
   output logic o_active
);
   localparam int CW = $clog2(TMO + 1);
   logic s1_ff, s2_ff, s3_ff, act_ff, nxt_act;
   logic [CW-1:0] cnt_ff, nxt_cnt;

   always_comb begin
      nxt_act = act_ff;
      nxt_cnt = cnt_ff;
      if (s2_ff) begin
         nxt_act = 1'b1;
         nxt_cnt = '0;
      end else if (act_ff) begin
         // flag drops after the quiet time runs out, see RL6
         if (cnt_ff == CW'(TMO - 1)) begin
            nxt_act = 1'b0;
            nxt_cnt = '0;
         end else begin
            nxt_cnt = cnt_ff + CW'(1);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         act_ff <= 1'b0;
         cnt_ff <= '0;
      end else begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         act_ff <= nxt_act;
         cnt_ff <= nxt_cnt;
      end
   end

   assign o_lvl = s2_ff;
   assign o_rise = s2_ff & ~s3_ff;
   assign o_active = act_ff | s2_ff;

   chk_act_timeout: assert property (@(posedge i_clk) disable iff (i_rst) // see RL6
      act_ff && !s2_ff && cnt_ff == CW'(TMO - 1) |=> !act_ff)
      else $error("activity flag did not drop at timeout");
   chk_act_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see RL6
      $fell(s2_ff) |-> ##1 act_ff ##1 act_ff)
      else $error("activity flag dropped too early");
endmodule : dsw_act

// ==== verilog/dsw_chan.sv ====
// per channel pwm generator and target on-state
`timescale 1ns/1ps
`include "dsw_cfg.svh"
module dsw_chan import dsw_pkg::*; #(
   parameter int unsigned INT_DIV = `DSW_INT_DIV
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_in,
   input wire logic i_direct_only,
   input wire logic i_sleep,
   input wire logic i_force_off,
   input wire logic i_on,
   input wire logic [7:0] i_duty,
   input wire logic i_pwm_en,
   input wire logic i_clk_int,
   input wire logic i_dir_en,
   input wire logic [1:0] i_pr,
   input wire logic [7:0] i_delay,
   input wire logic i_ext_tick,
   output logic o_hson
);
   localparam int PW = $clog2(INT_DIV * 8) + 1;
   logic [PW-1:0] div_ff, nxt_div, lim;
   logic [7:0] ph_ff, nxt_ph, rel;
   logic hson_ff, nxt_hson, itick, tick, duty_term;

   always_comb begin
      lim = PW'((INT_DIV << i_pr) - 1);
      itick = (div_ff >= lim);
      nxt_div = itick ? '0 : div_ff + PW'(1);
      tick = i_clk_int ? itick : i_ext_tick; // see RL11 see RL12 see RL13
      nxt_ph = tick ? ph_ff + 8'h01 : ph_ff;
      rel = ph_ff - i_delay;
      duty_term = (rel < i_duty); // see RL9
      if (i_sleep || i_force_off) begin
         nxt_hson = 1'b0; // see RL23
      end else if (i_direct_only) begin
         nxt_hson = i_in; // see RL10 see RL14
      end else begin
         nxt_hson = (i_in & i_dir_en) | (i_on & (i_pwm_en ? duty_term : 1'b1)); // see RL8
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_ff <= '0;
         ph_ff <= 8'h00;
         hson_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         ph_ff <= nxt_ph;
         hson_ff <= nxt_hson;
      end
   end

   assign o_hson = hson_ff;

   chk_direct_follow: assert property (@(posedge i_clk) disable iff (i_rst) // see RL14
      i_direct_only && !i_force_off && !i_sleep |=> o_hson == $past(i_in))
      else $error("direct control not followed");
   chk_fault_off: assert property (@(posedge i_clk) disable iff (i_rst) // see RL23
      i_force_off |=> !o_hson)
      else $error("faulted channel not forced off");
   chk_pwm_off: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
      !i_direct_only && !i_in && !i_on |=> !o_hson)
      else $error("channel on without any on term");
endmodule : dsw_chan

// ==== verilog/dsw_top.sv ====
// dual switch mode sequencer, channel control and apb register file
// Functional notes
// RL1 - four modes: sleep, normal, fail-safe, fault
// RL2 - rising reset-release or input leaves sleep
// RL3 - wake resets registers, enters normal
// RL4 - normal flag only in normal mode
// RL5 - host toggles watchdog bit within timeout
// RL6 - input activity flag drops after timeout
// RL7 - no activity and release low: sleep
// RL8 - on-state from direct, pwm or on bit
// RL9 - duty term from eight-bit duty field
// RL10 - direct mode follows input level
// RL11 - internal clock select drives channel pwm
// RL12 - external clock sets pwm frequency
// RL13 - pwm source selectable through registers only
// RL14 - release low or fail-safe: direct only
// RL15 - slow direct toggling needs release high
// RL16 - per channel duty, delay, slew, options; the code has no slew setting
// RL17 - status shows on/off and fault per channel
// RL18 - readback needs serial supply present
// RL19 - parallel option drives outputs together
// RL20 - wake is release or activity flags
// RL21 - watchdog disable bit blocks fail-safe entry
// RL22 - watchdog bit is bit fifteen, any word
// RL23 - faulted channel forced off in fault
`timescale 1ns/1ps
`include "dsw_cfg.svh"
module dsw_top import dsw_pkg::*; #(
   parameter int unsigned IN_TMO_CYC = `DSW_T_IN_MS * `DSW_CYC_PER_MS,
   parameter int unsigned WDTO_CYC = `DSW_T_WDTO_MS * `DSW_CYC_PER_MS,
   parameter int unsigned AVAIL_CYC = `DSW_T_AVAIL_US * `DSW_CLK_MHZ,
   parameter int unsigned INT_DIV = `DSW_INT_DIV
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_reset_release_input,
   input wire logic i_in0,
   input wire logic i_in1,
   input wire logic i_ext_clk,
   input wire logic i_vdd_ok,
   input wire logic [1:0] i_prot_fault,
   input wire logic i_uv_fault,
   output logic o_first_power_output,
   output logic o_second_power_output,
   output logic o_normal_mode_flag,
   output logic o_fail_safe_n,
   output logic o_fault_n,
   output logic o_func_ready
);
   localparam int WW = $clog2(WDTO_CYC + 1);
   localparam int AW = $clog2(AVAIL_CYC + 1);

   function automatic logic [7:0] ch_addr(input logic [7:0] base, input int i);
      ch_addr = base + 8'(i) * `DSW_A_CH_STEP;
   endfunction : ch_addr

   logic rst_lvl, rst_rise, vdd_lvl, ck_rise;
   logic [1:0] in_lvl, in_rise, in_act, hson;
   logic wake, fault, sleep_now;

   dsw_act #(.TMO(IN_TMO_CYC)) u_rst (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_reset_release_input),
      .o_lvl(rst_lvl), .o_rise(rst_rise), .o_active());
   dsw_act #(.TMO(IN_TMO_CYC)) u_in0 (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_in0),
      .o_lvl(in_lvl[0]), .o_rise(in_rise[0]), .o_active(in_act[0]));
   dsw_act #(.TMO(IN_TMO_CYC)) u_in1 (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_in1),
      .o_lvl(in_lvl[1]), .o_rise(in_rise[1]), .o_active(in_act[1]));
   dsw_act #(.TMO(IN_TMO_CYC)) u_ck (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_ext_clk),
      .o_lvl(), .o_rise(ck_rise), .o_active());
   dsw_act #(.TMO(IN_TMO_CYC)) u_vdd (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_vdd_ok),
      .o_lvl(vdd_lvl), .o_rise(), .o_active());

   // apb slave, one wait state: pready rises in the second access cycle
   logic rdy_ff, nxt_rdy, err_ff, nxt_err, wr_go, rd_go, hit;
   logic [31:0] rd_ff, nxt_rd, rdata;
   assign wr_go = i_psel & i_penable & rdy_ff & i_pwrite;
   assign rd_go = i_psel & i_penable & rdy_ff & ~i_pwrite;

   dsw_mode_t mode_ff, nxt_mode;
   logic [15:0] gcr_ff, nxt_gcr;
   logic [15:0] pwmr_ff [2];
   logic [15:0] nxt_pwmr [2];
   logic [15:0] confr_ff [2];
   logic [15:0] nxt_confr [2];
   logic [15:0] ocr_ff [2];
   logic [15:0] nxt_ocr [2];
   logic [1:0] flt_ff, nxt_flt, out_ff, nxt_out;
   logic fs_ff, nxt_fs, arm_ff, nxt_arm, run_ff, nxt_run, last_ff, nxt_last;
   logic [WW-1:0] wd_ff, nxt_wd;
   logic [AW-1:0] av_ff, nxt_av;
   logic nm_ff, fsn_ff, fltn_ff, ready_ff;
   logic fs_set, fs_clr, regs_clr, watchdog_disable_bit, par;

   assign watchdog_disable_bit = gcr_ff[`DSW_GCR_WDDIS];
   assign par = gcr_ff[`DSW_GCR_PAR];
   assign wake = rst_lvl | in_act[0] | in_act[1]; // see RL20
   assign fault = (|i_prot_fault) | i_uv_fault;
   assign sleep_now = (mode_ff == DSW_SLEEP);

   // mode sequencer, see RL1
   always_comb begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         DSW_SLEEP: begin
            if (rst_rise || (|in_rise)) begin
               nxt_mode = DSW_NORMAL; // see RL2 see RL3
            end
         end
         DSW_NORMAL, DSW_FAILSAFE, DSW_FAULT: begin
            if (!wake) begin
               nxt_mode = DSW_SLEEP; // see RL7 see RL20
            end else if (fault) begin
               nxt_mode = DSW_FAULT;
            end else if (fs_ff) begin
               nxt_mode = DSW_FAILSAFE;
            end else begin
               nxt_mode = DSW_NORMAL;
            end
         end
         default: nxt_mode = DSW_SLEEP;
      endcase
   end

   // serial watchdog on bit fifteen of every written word
   always_comb begin
      nxt_fs = fs_ff;
      nxt_arm = arm_ff;
      nxt_run = run_ff;
      nxt_last = last_ff;
      nxt_wd = wd_ff;
      fs_set = 1'b0;
      fs_clr = 1'b0;
      if (sleep_now) begin
         nxt_fs = 1'b0;
         nxt_arm = 1'b0;
         // the release edge that wakes the block also starts the watchdog
         nxt_run = rst_rise;
         nxt_wd = '0;
      end else if (rst_rise) begin
         nxt_run = 1'b1;
         nxt_wd = '0;
      end else if (fs_ff) begin
         // recovery: a word with the bit set, then another within the timeout
         if (wr_go && arm_ff) begin
            nxt_fs = 1'b0;
            nxt_arm = 1'b0;
            nxt_wd = '0;
            fs_clr = 1'b1;
         end else if (wr_go && i_pwdata[`DSW_WD_BIT]) begin
            nxt_arm = 1'b1;
            nxt_wd = '0;
         end else if (arm_ff) begin
            if (wd_ff == WW'(WDTO_CYC - 1)) begin
               nxt_arm = 1'b0;
            end
            nxt_wd = wd_ff + WW'(1);
         end
         if (wr_go) begin
            nxt_last = i_pwdata[`DSW_WD_BIT];
         end
      end else if (wr_go) begin
         if (i_pwdata[`DSW_WD_BIT] != last_ff) begin
            nxt_wd = '0; // see RL22 see RL5
         end
         nxt_last = i_pwdata[`DSW_WD_BIT];
      end else if (run_ff && rst_lvl && !watchdog_disable_bit) begin
         if (wd_ff == WW'(WDTO_CYC - 1)) begin
            nxt_fs = 1'b1; // see RL21
            nxt_wd = '0;
            fs_set = 1'b1;
         end else begin
            nxt_wd = wd_ff + WW'(1);
         end
      end
   end

   assign regs_clr = sleep_now | fs_set | fs_clr;

   // register file; writes blocked in fail-safe
   always_comb begin
      nxt_gcr = gcr_ff;
      nxt_pwmr = pwmr_ff;
      nxt_confr = confr_ff;
      nxt_ocr = ocr_ff;
      nxt_flt = flt_ff;
      if (wr_go && !fs_ff) begin
         if (i_paddr == `DSW_A_GCR) begin
            nxt_gcr = i_pwdata[15:0];
         end
         for (int i = 0; i < 2; i++) begin
            if (i_paddr == ch_addr(`DSW_A_PWMR0, i)) begin
               nxt_pwmr[i] = i_pwdata[15:0]; // see RL16
            end
            if (i_paddr == ch_addr(`DSW_A_CONFR0, i)) begin
               nxt_confr[i] = i_pwdata[15:0]; // see RL16
            end
            if (i_paddr == ch_addr(`DSW_A_OCR0, i)) begin
               nxt_ocr[i] = i_pwdata[15:0]; // see RL16
            end
         end
      end
      if (regs_clr) begin
         nxt_gcr = `DSW_RST_GCR; // see RL3
         nxt_pwmr = '{`DSW_RST_PWMR, `DSW_RST_PWMR};
         nxt_confr = '{`DSW_RST_CONFR, `DSW_RST_CONFR};
         nxt_ocr = '{`DSW_RST_OCR, `DSW_RST_OCR};
         nxt_flt = 2'h0;
         if (!sleep_now) begin
            nxt_gcr[`DSW_GCR_PAR] = par;
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (rd_go && i_paddr == ch_addr(`DSW_A_FLTR0, i) && !i_prot_fault[i]) begin
            nxt_flt[i] = 1'b0;
         end
         if (i_prot_fault[i]) begin
            nxt_flt[i] = 1'b1; // see RL17
         end
      end
   end

   // read mux, see RL17
   always_comb begin
      rdata = 32'h0000_0000;
      hit = 1'b1;
      if (i_paddr == `DSW_A_GCR) begin
         rdata = {16'h0000, gcr_ff};
      end else if (i_paddr == `DSW_A_GLOBAL_STATUS_REGISTER) begin
         rdata = {21'h00_0000, fs_ff, ready_ff, nm_ff, mode_ff, flt_ff, out_ff};
      end else begin
         hit = 1'b0;
         for (int i = 0; i < 2; i++) begin
            if (i_paddr == ch_addr(`DSW_A_PWMR0, i)) begin
               rdata = {16'h0000, pwmr_ff[i]};
               hit = 1'b1;
            end
            if (i_paddr == ch_addr(`DSW_A_CONFR0, i)) begin
               rdata = {16'h0000, confr_ff[i]};
               hit = 1'b1;
            end
            if (i_paddr == ch_addr(`DSW_A_OCR0, i)) begin
               rdata = {16'h0000, ocr_ff[i]};
               hit = 1'b1;
            end
            if (i_paddr == ch_addr(`DSW_A_FLTR0, i)) begin
               rdata = {31'h0000_0000, flt_ff[i]};
               hit = 1'b1;
            end
         end
      end
   end

   always_comb begin
      nxt_rdy = i_psel & i_penable & ~rdy_ff;
      nxt_rd = rd_ff;
      nxt_err = err_ff;
      if (nxt_rdy) begin
         nxt_err = ~hit | (~i_pwrite & ~vdd_lvl); // see RL18
         nxt_rd = (hit && !i_pwrite && vdd_lvl) ? rdata : 32'h0000_0000;
      end else if (!i_psel) begin
         nxt_err = 1'b0;
         nxt_rd = 32'h0000_0000;
      end
   end

   // channels; parallel mode copies channel 0 onto both outputs
   for (genvar g = 0; g < 2; g++) begin : g_ch
      dsw_chan #(.INT_DIV(INT_DIV)) u_chan (
         .i_clk(i_clk), .i_rst(i_rst), .i_in(in_lvl[g]),
         .i_direct_only(~rst_lvl | fs_ff), // see RL14
         .i_sleep(sleep_now),
         .i_force_off((mode_ff == DSW_FAULT) & (i_prot_fault[g] | i_uv_fault)), // see RL23
         .i_on(pwmr_ff[g][`DSW_PW_ON]),
         .i_duty(pwmr_ff[g][`DSW_PW_DUTY_LO +: 8]),
         .i_pwm_en(confr_ff[g][`DSW_CF_PWMEN]),
         .i_clk_int(confr_ff[g][`DSW_CF_CLKINT]),
         .i_dir_en(confr_ff[g][`DSW_CF_DIREN]),
         .i_pr(ocr_ff[g][`DSW_OC_PR_LO +: 2]),
         .i_delay(confr_ff[g][`DSW_CF_DLY_LO +: 8]),
         .i_ext_tick(ck_rise),
         .o_hson(hson[g]));
   end

   always_comb begin
      nxt_out = {par ? hson[0] : hson[1], hson[0]}; // see RL19
      nxt_av = av_ff;
      if (sleep_now) begin
         nxt_av = '0;
      end else if (av_ff != AW'(AVAIL_CYC)) begin
         nxt_av = av_ff + AW'(1); // see RL3
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_ff <= DSW_SLEEP;
         gcr_ff <= `DSW_RST_GCR;
         pwmr_ff <= '{`DSW_RST_PWMR, `DSW_RST_PWMR};
         confr_ff <= '{`DSW_RST_CONFR, `DSW_RST_CONFR};
         ocr_ff <= '{`DSW_RST_OCR, `DSW_RST_OCR};
         flt_ff <= 2'h0;
         out_ff <= 2'h0;
         fs_ff <= 1'b0;
         arm_ff <= 1'b0;
         run_ff <= 1'b0;
         last_ff <= 1'b0;
         wd_ff <= '0;
         av_ff <= '0;
         rdy_ff <= 1'b0;
         err_ff <= 1'b0;
         rd_ff <= 32'h0000_0000;
         nm_ff <= 1'b0;
         fsn_ff <= 1'b1;
         fltn_ff <= 1'b1;
         ready_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         gcr_ff <= nxt_gcr;
         pwmr_ff <= nxt_pwmr;
         confr_ff <= nxt_confr;
         ocr_ff <= nxt_ocr;
         flt_ff <= nxt_flt;
         out_ff <= nxt_out;
         fs_ff <= nxt_fs;
         arm_ff <= nxt_arm;
         run_ff <= nxt_run;
         last_ff <= nxt_last;
         wd_ff <= nxt_wd;
         av_ff <= nxt_av;
         rdy_ff <= nxt_rdy;
         err_ff <= nxt_err;
         rd_ff <= nxt_rd;
         nm_ff <= (mode_ff == DSW_NORMAL); // see RL4
         fsn_ff <= ~fs_ff;
         fltn_ff <= ~fault;
         ready_ff <= ~sleep_now & (av_ff == AW'(AVAIL_CYC));
      end
   end

   assign o_prdata = rd_ff;
   assign o_pready = rdy_ff;
   assign o_pslverr = err_ff;
   assign o_first_power_output = out_ff[0];
   assign o_second_power_output = out_ff[1];
   assign o_normal_mode_flag = nm_ff;
   assign o_fail_safe_n = fsn_ff;
   assign o_fault_n = fltn_ff;
   assign o_func_ready = ready_ff;

   chk_sleep_off: assert property (@(posedge i_clk) disable iff (i_rst) // see RL7
      sleep_now ##1 sleep_now |-> ##2 out_ff == 2'h0)
      else $error("output on in sleep");
   chk_wake_edge: assert property (@(posedge i_clk) disable iff (i_rst) // see RL2
      sleep_now && (rst_rise || (|in_rise)) |=> mode_ff == DSW_NORMAL)
      else $error("no wake on rising edge");
   chk_sleep_entry: assert property (@(posedge i_clk) disable iff (i_rst) // see RL20
      !sleep_now && !wake |=> sleep_now)
      else $error("sleep not entered");
   chk_nm_flag: assert property (@(posedge i_clk) disable iff (i_rst) // see RL4
      nm_ff |-> $past(mode_ff) == DSW_NORMAL && $past(wake, 2) && !$past(fs_ff, 2))
      else $error("normal flag wrong");
   chk_wd_disable: assert property (@(posedge i_clk) disable iff (i_rst) // see RL21
      watchdog_disable_bit && !fs_ff |=> !fs_ff)
      else $error("fail-safe despite watchdog disable");
   chk_wake_reset: assert property (@(posedge i_clk) disable iff (i_rst) // see RL3
      sleep_now |=> pwmr_ff[0] == `DSW_RST_PWMR && confr_ff[1] == `DSW_RST_CONFR)
      else $error("registers not reset on wake");
   chk_par_sync: assert property (@(posedge i_clk) disable iff (i_rst) // see RL19
      par |=> out_ff[1] == out_ff[0])
      else $error("parallel outputs differ");
   chk_fault_sticky: assert property (@(posedge i_clk) disable iff (i_rst) // see RL17
      i_prot_fault[0] |=> flt_ff[0])
      else $error("fault bit not set");
endmodule : dsw_top

// ==== testbench/dsw_host.sv ====
// host controller model: apb master and direct pin driver
`timescale 1ns/1ps
module dsw_host (
   input wire logic i_clk,
   input wire logic i_pready,
   output logic o_psel = 1'b0,
   output logic o_penable = 1'b0,
   output logic o_pwrite = 1'b0,
   output logic [7:0] o_paddr = 8'h00,
   output logic [31:0] o_pwdata = 32'h00000000,
   output logic o_rel = 1'b0,
   output logic o_in0 = 1'b0,
   output logic o_in1 = 1'b0
);
   logic wd = 1'b0;
   task xfer(input logic w, input logic [7:0] a, input logic [14:0] d);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= {16'h0000, ~wd, d};
      if (w) begin
         wd <= ~wd;
      end
      @(posedge i_clk);
      o_penable <= 1'b1;
      @(posedge i_clk);
      while (i_pready !== 1'b1) begin
         @(posedge i_clk);
      end
      o_psel <= 1'b0;
      o_penable <= 1'b0;
   endtask : xfer
   task pins(input logic r, input logic a, input logic b);
      @(posedge i_clk);
      o_rel <= r;
      o_in0 <= a;
      o_in1 <= b;
   endtask : pins
endmodule : dsw_host

// ==== testbench/dsw_top_test.sv ====
// self-checking bench for the dual switch mode sequencer
`timescale 1ns/1ps
module dsw_top_test;
   localparam int IN_TMO = 50;
   localparam int WDTO = 80;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic rel, in0, in1, out0, out1, nm, fs_n, flt_n, frdy, e;
   logic ext_clk = 1'b0;
   logic ext_run = 1'b0;
   logic vdd_ok = 1'b1;
   logic uv = 1'b0;
   logic [1:0] prot = 2'b00;
   logic [33:0] expq[$];
   logic [33:0] ent;
   int miscompares = 0;
   int num_checks = 0;
   int seed = 94511;
   int cnt;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (ext_run) begin
         ext_clk <= ~ext_clk;
      end
   end
   dsw_host u_dsw_host (.i_clk(clk), .i_pready(pready), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata), .o_rel(rel), .o_in0(in0), .o_in1(in1));
   dsw_top #(.IN_TMO_CYC(IN_TMO), .WDTO_CYC(WDTO), .AVAIL_CYC(20), .INT_DIV(4)) u_dsw_top (.i_clk(clk),
      .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_reset_release_input(rel), .i_in0(in0),
      .i_in1(in1), .i_ext_clk(ext_clk), .i_vdd_ok(vdd_ok), .i_prot_fault(prot), .i_uv_fault(uv),
      .o_first_power_output(out0), .o_second_power_output(out1), .o_normal_mode_flag(nm),
      .o_fail_safe_n(fs_n), .o_fault_n(flt_n), .o_func_ready(frdy));
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         $display("[ERR] %s expected %h seen %h", s, x, g);
         miscompares++;
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task rd(input logic [7:0] a, input logic [15:0] x, input logic er);
      expq.push_back({1'b1, er, 16'h0000, x});
      u_dsw_host.xfer(1'b0, a, 15'h0000);
   endtask : rd
   task wr(input logic [7:0] a, input logic [14:0] d);
      expq.push_back({2'b00, 32'h00000000});
      u_dsw_host.xfer(1'b1, a, d);
   endtask : wr
   task meas(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         c += int'(out0 === 1'b1);
      end
   endtask : meas
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   // answer monitor: oldest note against each completed transfer
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (expq.size() == 0) begin
            chk("stray answer", 0, 1);
         end else begin
            ent = expq.pop_front();
            chk("pslverr", 32'(ent[32]), 32'(pslverr));
            if (ent[33]) begin
               chk("prdata", ent[31:0], prdata);
            end
         end
      end
   end
   initial begin
      repeat (12000) @(posedge clk);
      miscompares++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wt(3);
      chk("sleep nm", 0, 32'(nm));
      chk("sleep outs", 0, 32'({out1, out0}));
      u_dsw_host.pins(1'b0, 1'b1, 1'b0);
      wt(8);
      chk("input wake", 1, 32'(nm));
      chk("direct on", 1, 32'(out0));
      u_dsw_host.pins(1'b0, 1'b0, 1'b0);
      wt(8);
      chk("direct off", 0, 32'(out0));
      chk("activity held", 1, 32'(nm));
      wt(IN_TMO + 4);
      chk("resleep", 0, 32'(nm));
      $display("end direct wake");
      u_dsw_host.pins(1'b1, 1'b0, 1'b0);
      wt(6);
      chk("release wake", 1, 32'(nm));
      chk("not ready", 0, 32'(frdy));
      wt(22);
      chk("ready", 1, 32'(frdy));
      wr(8'h00, 15'h0000);
      rd(8'h0C, 16'h0004, 1'b0);
      rd(8'h04, 16'h0000, 1'b0);
      rd(8'h28, 16'h0000, 1'b1);
      vdd_ok <= 1'b0;
      wt(4);
      rd(8'h1C, 16'h0000, 1'b1);
      vdd_ok <= 1'b1;
      $display("end release wake");
      wt(WDTO + 10);
      chk("wd lapse", 0, 32'(fs_n));
      u_dsw_host.pins(1'b1, 1'b1, 1'b0);
      wt(8);
      chk("fs direct", 1, 32'(out0));
      chk("fs nm", 0, 32'(nm));
      repeat (4) wr(8'h00, 15'h0010);
      wt(4);
      chk("fs exit", 1, 32'(fs_n));
      wt(WDTO + 10);
      chk("wd disabled", 1, 32'(fs_n));
      $display("end watchdog");
      for (int k = 0; k < 24; k++) begin
         r = $random(seed);
         wr(8'h0C + {5'h00, r[4], 2'b00}, {12'h000, r[0], 1'b0, r[1]});
         wr(8'h04 + {5'h00, r[4], 2'b00}, {6'h00, r[2], 8'h00});
         u_dsw_host.pins(1'b1, r[3] & ~r[4], r[3] & r[4]);
         wt(8);
         e = (r[3] & r[0]) | (r[2] & ~r[1]);
         chk("target", 32'(e), 32'(r[4] ? out1 : out0));
      end
      $display("end target table");
      wr(8'h0C, 15'h0000);
      wr(8'h10, 15'h0000);
      wr(8'h04, 15'h0100);
      wr(8'h08, 15'h0100);
      wt(4);
      prot <= 2'b01;
      wt(4);
      chk("fault outs", 2, 32'({out1, out0}));
      chk("fault pin", 0, 32'(flt_n));
      chk("fault nm", 0, 32'(nm));
      rd(8'h20, 16'h0001, 1'b0);
      prot <= 2'b00;
      wt(4);
      rd(8'h20, 16'h0001, 1'b0);
      rd(8'h20, 16'h0000, 1'b0);
      uv <= 1'b1;
      wt(4);
      chk("uv outs", 0, 32'({out1, out0}));
      uv <= 1'b0;
      wt(6);
      chk("restored", 3, 32'({out1, out0}));
      wr(8'h08, 15'h0000);
      wr(8'h00, 15'h0011);
      wt(4);
      chk("parallel", 3, 32'({out1, out0}));
      $display("end fault");
      wr(8'h04, 15'h0180);
      wr(8'h0C, 15'h0003);
      meas(1024, cnt);
      chk("int duty", 1, 32'(cnt > 500 && cnt < 524));
      wr(8'h0C, 15'h0001);
      ext_run <= 1'b1;
      meas(512, cnt);
      chk("ext duty", 1, 32'(cnt > 240 && cnt < 272));
      ext_run <= 1'b0;
      wt(4);
      meas(512, cnt);
      chk("ext stopped", 1, 32'(cnt == 0 || cnt == 512));
      $display("end pwm");
      wt(2);
      close_out();
   end
endmodule : dsw_top_test
